// ### src/pac_pkg.sv
package pac_pkg;
  // Each register index sits at byte address index * 4.
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h06;
  localparam logic [7:0] IDX_ACC_CTRL = 8'h20;
  localparam logic [7:0] IDX_ACC_FLAGS = 8'h21;
  localparam logic [7:0] IDX_ACC_COUNT = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

  localparam int TSC_TIMER_EN_BIT = 7;
  localparam int TSC_FFCA_BIT = 4;
  localparam int CTRL_EN_BIT = 6;
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int FLG_OVF_BIT = 1;
  localparam int FLG_EDGE_BIT = 0;

  localparam logic [7:0] TSC_MASK = 8'h90;
  localparam logic [7:0] CTRL_MASK = 8'h70;
  localparam logic [7:0] TSC_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam int PRESCALE_DIV = 64;
  localparam int PRESC_W = 6;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESCALE_DIV - 1);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ### src/pac_accumulator.sv
`timescale 1ns/100ps
module pac_accumulator (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_accumulator_input_pin,
  output logic o_irq
);
  import pac_pkg::*;

  function automatic logic [7:0] reg_idx(input logic [31:0] addr);
    reg_idx = addr[9:2];
  endfunction

  logic [7:0] tsc_q;
  logic [7:0] ctrl_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [15:0] count_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [PRESC_W-1:0] presc_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic dph_acc_q;
  logic dph_wr_q;
  logic [7:0] dph_idx_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  logic irq_q;

  logic addr_ok;
  logic [7:0] addr_idx;
  logic [31:0] rd_word;
  logic timer_enable;
  logic accumulator_enable;
  logic gated_mode;
  logic accumulator_edge_select;
  logic pin_rise;
  logic pin_fall;
  logic sel_edge;
  logic presc_tick;
  logic gate_open;
  logic inc;
  logic edge_evt;
  logic ovf_evt;
  logic cnt_acc;
  logic cnt_wr;
  logic flg_wr;
  logic stat_rd;
  logic [1:0] flag_clr;
  logic [1:0] events;

  // Only whole-word transfers are taken; other sizes are answered OKAY and have no effect.
  assign addr_ok = i_hsel & i_hready & i_htrans[1] & (i_hsize == HSIZE_WORD);
  assign addr_idx = reg_idx(i_haddr);

  assign timer_enable = tsc_q[TSC_TIMER_EN_BIT];
  assign accumulator_enable = ctrl_q[CTRL_EN_BIT];
  assign gated_mode = ctrl_q[CTRL_MODE_BIT];
  assign accumulator_edge_select = ctrl_q[CTRL_EDGE_BIT];

  assign pin_rise = pin_sync_q & ~pin_prev_q;
  assign pin_fall = ~pin_sync_q & pin_prev_q;
  // The counted edge in event mode is also the trailing edge of the gate in gated mode.
  assign sel_edge = accumulator_edge_select ? pin_rise : pin_fall;
  assign presc_tick = (presc_q == PRESC_LAST);
  assign gate_open = (pin_sync_q != accumulator_edge_select);
  assign inc = accumulator_enable & (gated_mode ? (gate_open & presc_tick) : sel_edge);
  assign edge_evt = accumulator_enable & sel_edge;

  assign cnt_acc = dph_acc_q & (dph_idx_q == IDX_ACC_COUNT);
  assign cnt_wr = cnt_acc & dph_wr_q;
  assign flg_wr = dph_acc_q & dph_wr_q & (dph_idx_q == IDX_ACC_FLAGS);
  assign stat_rd = addr_ok & ~i_hwrite & (addr_idx == IDX_IRQ_STATUS);
  // A load in the same cycle as an edge wins, so no overflow is flagged then.
  assign ovf_evt = inc & ~cnt_wr & (count_q == COUNT_MAX);
  assign events = {ovf_evt, edge_evt};

  always_comb begin
    flag_clr = 2'h0;
    if (cnt_acc && tsc_q[TSC_FFCA_BIT]) begin
      flag_clr = 2'h3;
    end else if (flg_wr && (timer_enable || accumulator_enable)) begin
      flag_clr = i_hwdata[1:0];
    end
  end

  // Setting wins over clearing so an event in the clearing cycle survives.
  assign flags_d = (flags_q & ~flag_clr) | events;
  assign irq_stat_d = (irq_stat_q & ~{2{stat_rd}}) | events;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr_idx)
      IDX_TIMER_CTRL: rd_word = {24'h00_0000, tsc_q};
      IDX_ACC_CTRL: rd_word = {24'h00_0000, ctrl_q};
      IDX_ACC_FLAGS: rd_word = {30'h0000_0000, flags_q};
      IDX_ACC_COUNT: rd_word = {16'h0000, count_q};
      IDX_IRQ_STATUS: rd_word = {30'h0000_0000, irq_stat_q};
      IDX_IRQ_MASK: rd_word = {30'h0000_0000, irq_mask_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Two stages before any logic looks at the pin.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= i_accumulator_input_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Reads are answered with zero wait states, so read data is captured in the address phase.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dph_acc_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_idx_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      dph_acc_q <= addr_ok;
      dph_wr_q <= addr_ok & i_hwrite;
      dph_idx_q <= addr_idx;
      hrdata_q <= (addr_ok && !i_hwrite) ? rd_word : 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tsc_q <= TSC_RESET;
      ctrl_q <= CTRL_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (dph_acc_q && dph_wr_q) begin
      case (dph_idx_q)
        IDX_TIMER_CTRL: tsc_q <= i_hwdata[7:0] & TSC_MASK;
        IDX_ACC_CTRL: ctrl_q <= i_hwdata[7:0] & CTRL_MASK;
        IDX_IRQ_MASK: irq_mask_q <= i_hwdata[1:0];
        default: tsc_q <= tsc_q;
      endcase
    end
  end

  // The divider only runs in gated mode so that the first gated tick is a full period away.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      presc_q <= '0;
    end else if (accumulator_enable && gated_mode) begin
      presc_q <= presc_q + PRESC_W'(1);
    end else begin
      presc_q <= '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count_q <= COUNT_RESET;
    end else if (cnt_wr) begin
      count_q <= i_hwdata[15:0];
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      flags_q <= FLAGS_RESET;
      irq_stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign o_hreadyout = hready_q;
  assign o_hresp = hresp_q;
  assign o_hrdata = hrdata_q;
  assign o_irq = irq_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_fast_clear;
    cnt_acc && tsc_q[TSC_FFCA_BIT] && !inc && !edge_evt |=> flags_q == 2'h0;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast clear left a flag set");

  property p_event_count;
    accumulator_enable && !gated_mode && sel_edge && !cnt_wr |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_event_count: assert property (p_event_count) else $error("selected edge did not count");

  property p_overflow;
    inc && !cnt_wr && count_q == COUNT_MAX |=> count_q == 16'h0000 && flags_q[FLG_OVF_BIT] && irq_stat_q[FLG_OVF_BIT];
  endproperty
  a_overflow: assert property (p_overflow) else $error("wrap did not set overflow");

  property p_sync;
    $rose(pin_sync_q) |-> $past(i_accumulator_input_pin, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin reached logic without two stages");

  property p_w1c_locked;
    flg_wr && !timer_enable && !accumulator_enable |=> flags_q == $past(flags_q);
  endproperty
  a_w1c_locked: assert property (p_w1c_locked) else $error("flag cleared while both enables low");

  property p_wrong_edge;
    accumulator_enable && !gated_mode && !sel_edge && !cnt_wr |=> $stable(count_q);
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("unselected edge changed count");

  property p_gate_closed;
    accumulator_enable && gated_mode && !(gate_open && presc_tick) && !cnt_wr |=> $stable(count_q);
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("count moved outside gated tick");

  property p_gate_trailing;
    accumulator_enable && gated_mode && sel_edge |=> flags_q[FLG_EDGE_BIT];
  endproperty
  a_gate_trailing: assert property (p_gate_trailing) else $error("gate trailing edge missed flag");

  property p_disabled;
    !accumulator_enable && !cnt_wr |=> $stable(count_q) && (!flags_q[FLG_EDGE_BIT] || $past(flags_q[FLG_EDGE_BIT]));
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled accumulator moved");

  property p_load;
    cnt_wr |=> count_q == $past(i_hwdata[15:0]);
  endproperty
  a_load: assert property (p_load) else $error("count write not loaded");

  property p_w1c_clear;
    flg_wr && (timer_enable || accumulator_enable) && i_hwdata[FLG_EDGE_BIT] && !edge_evt |=> !flags_q[FLG_EDGE_BIT];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("enabled flag write did not clear");

  property p_edge_flag;
    accumulator_enable && !gated_mode && sel_edge |=> flags_q[FLG_EDGE_BIT] && irq_stat_q[FLG_EDGE_BIT];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("counted edge did not set the edge flag");

  property p_gated_inc;
    accumulator_enable && gated_mode && gate_open && presc_tick && !cnt_wr |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_gated_inc: assert property (p_gated_inc) else $error("open gate tick did not count");

  property p_irq_high;
    (irq_stat_q & irq_mask_q) != 2'h0 |=> o_irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("unmasked status did not raise the interrupt");

  property p_irq_low;
    (irq_stat_q & irq_mask_q) == 2'h0 |=> !o_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt high without unmasked status");

  property p_read_clear;
    stat_rd && events == 2'h0 |=> irq_stat_q == 2'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear the status");

  property p_rdata_idle;
    !(addr_ok && !i_hwrite) |=> o_hrdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data shown outside a read data phase");

  c_overflow: cover property (ovf_evt);
  c_gated_inc: cover property (accumulator_enable && gated_mode && inc);
  c_fast_clear: cover property (cnt_acc && tsc_q[TSC_FFCA_BIT] && flags_q != 2'h0);
  c_irq: cover property ($rose(o_irq));
endmodule

// ### dv/pac_pulse_src.sv
`timescale 1ns/100ps
// Pulse source on the input pin: i_count pulses, high and low for i_width cycles each.
// The pin idles low between bursts, as an undriven pin would not.
module pac_pulse_src (
  input wire logic i_ref_clk,
  input wire logic i_start,
  input wire logic [3:0] i_count,
  input wire logic [15:0] i_width,
  output logic o_pin,
  output logic o_busy
);
  logic [3:0] left_q;
  logic [15:0] tick_q;
  initial begin
    o_pin = 1'b0;
    o_busy = 1'b0;
    left_q = 4'h0;
    tick_q = 16'h0000;
  end
  always @(posedge i_ref_clk) begin
    if (i_start) begin
      left_q <= i_count;
      tick_q <= i_width;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      if (tick_q > 16'h0001) begin
        tick_q <= tick_q - 16'h0001;
      end else begin
        tick_q <= i_width;
        o_pin <= ~o_pin;
        if (o_pin && left_q == 4'h1) begin
          o_busy <= 1'b0;
        end
        if (o_pin) begin
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [2:0] bsize = HSIZE_WORD;
  logic hrdy, hresp, irq, pin, busy;
  logic [31:0] hrdata, rd;
  logic start = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [15:0] wid = 16'h0004;
  int miscompares = 0;
  int n_checks = 0;
  initial forever #5 clk = ~clk;
  pac_accumulator pac_accumulator_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hrdy), .i_hwdata(hwdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_accumulator_input_pin(pin), .o_irq(irq));
  pac_pulse_src pac_pulse_src_inst (.i_ref_clk(clk), .i_start(start), .i_count(cnt), .i_width(wid),
    .o_pin(pin), .o_busy(busy));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  // Waits for hready at a rising edge; a bus that never answers ends the run.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hrdy !== 1'b1 && k < 50);
    if (hrdy !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= bsize;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask
  // Sends n pulses and leaves time for the two-flop synchroniser and the count update.
  task automatic pulses(input logic [3:0] n, input logic [15:0] w);
    int k;
    cnt <= n;
    wid <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    k = 0;
    while (busy === 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (busy === 1'b1) begin
      miscompares++;
      test_done();
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset_and_map();
    rchk("count", IDX_ACC_COUNT, 32'h0);
    rchk("flags", IDX_ACC_FLAGS, 32'h0);
    rchk("tsc", IDX_TIMER_CTRL, 32'h0);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h10, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_events();
    bus(1'b1, IDX_ACC_CTRL, 32'h50);
    pulses(4'h3, 16'h0004);
    rchk("rise count", IDX_ACC_COUNT, 32'h3);
    rchk("edge flag", IDX_ACC_FLAGS, 32'h1);
    bus(1'b1, IDX_ACC_CTRL, 32'h0);
    pulses(4'h2, 16'h0004);
    rchk("disabled count", IDX_ACC_COUNT, 32'h3);
    bus(1'b1, IDX_ACC_FLAGS, 32'h1);
    rchk("w1c no enable", IDX_ACC_FLAGS, 32'h1);
    bus(1'b1, IDX_TIMER_CTRL, 32'h80);
    bus(1'b1, IDX_ACC_FLAGS, 32'h1);
    rchk("w1c timer on", IDX_ACC_FLAGS, 32'h0);
    bus(1'b1, IDX_TIMER_CTRL, 32'h0);
    bus(1'b1, IDX_ACC_CTRL, 32'h40);
    pulses(4'h2, 16'h0003);
    rchk("fall count", IDX_ACC_COUNT, 32'h5);
  endtask
  task automatic t_overflow_irq();
    bus(1'b0, IDX_IRQ_STATUS, 32'h0);
    bus(1'b1, IDX_IRQ_MASK, 32'h2);
    bus(1'b1, IDX_ACC_COUNT, 32'hFFFE);
    pulses(4'h1, 16'h0004);
    rchk("loaded+1", IDX_ACC_COUNT, 32'hFFFF);
    chk("irq masked", 32'h0, {31'h0, irq});
    pulses(4'h1, 16'h0004);
    rchk("wrap", IDX_ACC_COUNT, 32'h0);
    rchk("ovf flag", IDX_ACC_FLAGS, 32'h3);
    chk("irq set", 32'h1, {31'h0, irq});
    rchk("status", IDX_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, IDX_TIMER_CTRL, 32'h10);
    bus(1'b0, IDX_ACC_COUNT, 32'h0);
    rchk("fast clear", IDX_ACC_FLAGS, 32'h0);
  endtask
  task automatic t_gated();
    bus(1'b1, IDX_TIMER_CTRL, 32'h0);
    bus(1'b1, IDX_ACC_COUNT, 32'h0);
    bus(1'b1, IDX_ACC_CTRL, 32'h60);
    pulses(4'h1, 16'd192);
    rchk("gated count", IDX_ACC_COUNT, 32'h3);
    rchk("trailing flag", IDX_ACC_FLAGS, 32'h1);
  endtask
  // Narrow transfers must leave the count alone and read back zero.
  task automatic t_narrow();
    bsize = 3'h0;
    bus(1'b1, IDX_ACC_COUNT, 32'h0000_1234);
    bus(1'b0, IDX_ACC_COUNT, 32'h0);
    bsize = HSIZE_WORD;
    chk("narrow read", 32'h0, rd);
    rchk("narrow write", IDX_ACC_COUNT, 32'h3);
  endtask
  task automatic t_mid_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("count after reset", IDX_ACC_COUNT, 32'h0);
    rchk("flags after reset", IDX_ACC_FLAGS, 32'h0);
    rchk("ctrl after reset", IDX_ACC_CTRL, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_and_map();
    t_events();
    t_overflow_irq();
    t_gated();
    t_narrow();
    t_mid_reset();
    test_done();
  end
endmodule
